// *** common/nmm_pkg.sv ***
// constants shared by the nibble memory-op and multiplier block
`default_nettype none
package nmm_pkg;
	// opcode field values (upper byte of the instruction word)
	localparam logic [7:0] OP_XOR_BYTE = 8'h9e;
	localparam logic [7:0] OP_AND_LO   = 8'h80;
	localparam logic [7:0] OP_AND_HI   = 8'h81;
	localparam logic [7:0] OP_OR_LO    = 8'h90;
	localparam logic [7:0] OP_OR_HI    = 8'h91;
	localparam logic [7:0] OP_XOR_LO   = 8'h98;
	localparam logic [7:0] OP_XOR_HI   = 8'h99;
	localparam logic [7:0] OP_TST_LO   = 8'h88;
	localparam logic [7:0] OP_TST_HI   = 8'h89;
	localparam logic [7:0] OP_MUL_SW   = 8'haf;
	localparam logic [7:0] OP_MUL_UW   = 8'hab;
	localparam logic [7:0] OP_MUL_SH   = 8'hbf;
	// multiplier kinds
	localparam logic [1:0] MK_SW = 2'h0;
	localparam logic [1:0] MK_UW = 2'h1;
	localparam logic [1:0] MK_SH = 2'h2;
	// register byte offsets
	localparam logic [7:0] OFF_INSTR  = 8'h00;
	localparam logic [7:0] OFF_SRC    = 8'h04;
	localparam logic [7:0] OFF_DST    = 8'h08;
	localparam logic [7:0] OFF_FLAGS  = 8'h0c;
	localparam logic [7:0] OFF_PROD_H = 8'h10;
	localparam logic [7:0] OFF_PROD_L = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	// flag bit positions in the condition flags register
	localparam int FLAG_N = 3;
	localparam int FLAG_Z = 2;
	localparam int FLAG_V = 1;
	localparam int FLAG_C = 0;
	// reset values
	localparam logic [3:0]  FLAGS_RST = 4'h0;
	localparam logic [31:0] WORD_RST  = 32'h0000_0000;
	// nibble fill patterns for the immediate masks
	localparam logic [3:0] NIB_ONES = 4'hf;
	localparam logic [3:0] NIB_ZERO = 4'h0;
	// multiplier latency in cycles
	localparam int WORD_MUL_CYC = 5;
	localparam int HALF_MUL_CYC = 3;
endpackage : nmm_pkg
`default_nettype wire

// *** common/nmm_mul_if.sv ***
// carrier between the sequencer and the multiplier
`timescale 1ns/1ps
`default_nettype none
interface nmm_mul_if;
	logic        start;
	logic [1:0]  kind;
	logic [31:0] a;
	logic [31:0] b;
	logic        fin;
	logic        flag_n;
	logic        flag_z;
	logic        flag_v;
	logic        v_upd;
	logic [31:0] prod_hi;
	logic [31:0] prod_lo;
	modport ctl (output start, kind, a, b,
		input fin, flag_n, flag_z, flag_v, v_upd, prod_hi, prod_lo);
	modport mul (input start, kind, a, b,
		output fin, flag_n, flag_z, flag_v, v_upd, prod_hi, prod_lo);
endinterface : nmm_mul_if
`default_nettype wire

// *** core/nmm_mul.sv ***
// multi-cycle word and half-word multiplier holding the product registers
`timescale 1ns/1ps
`default_nettype none
module nmm_mul #(
	parameter int WORD_CYC = nmm_pkg::WORD_MUL_CYC,
	parameter int HALF_CYC = nmm_pkg::HALF_MUL_CYC
) (
	input  wire logic clk_i,
	input  wire logic rst_i,
	nmm_mul_if.mul    m
);
	typedef struct packed {
		logic [2:0]  cnt;
		logic [1:0]  kind;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] hi;
		logic [31:0] lo;
	} nmm_mul_st_t;

	nmm_mul_st_t q;
	nmm_mul_st_t n;
	logic [65:0] wide;
	logic [31:0] half;
	logic        sx;

	// one 33x33 product serves both word kinds; sign extension picks the kind
	assign sx   = (q.kind == nmm_pkg::MK_SW);
	assign wide = $signed({sx & q.a[31], q.a}) * $signed({sx & q.b[31], q.b});
	assign half = $signed(q.a[15:0]) * $signed(q.b[15:0]);

	// result lands on the last counted cycle
	always_comb begin
		n = q;
		m.fin = (q.cnt == 3'h1);
		if (m.start) begin
			n.kind = m.kind;
			n.a    = m.a;
			n.b    = m.b;
			n.cnt  = (m.kind == nmm_pkg::MK_SH) ? 3'(HALF_CYC - 1) : 3'(WORD_CYC - 1);
		end else if (q.cnt != 3'h0) begin
			n.cnt = q.cnt - 3'h1;
		end
		if (m.fin) begin
			if (q.kind == nmm_pkg::MK_SH) begin
				n.lo = half;
			end else begin
				n.hi = wide[63:32];
				n.lo = wide[31:0];
			end
		end
	end

	// flags from the product about to be stored
	always_comb begin
		m.flag_n = n.lo[31];
		m.v_upd  = (q.kind != nmm_pkg::MK_SH);
		unique case (q.kind)
			nmm_pkg::MK_SW: begin
				m.flag_z = (wide[63:0] == 64'h0);
				m.flag_v = (wide[63:32] != {32{wide[31]}});
			end
			nmm_pkg::MK_UW: begin
				m.flag_z = (wide[31:0] == 32'h0);
				m.flag_v = (wide[63:32] != 32'h0);
			end
			default: begin
				m.flag_z = (half == 32'h0);
				m.flag_v = 1'b0;
			end
		endcase
	end

	assign m.prod_hi = q.hi;
	assign m.prod_lo = q.lo;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_word_go;
		m.start && m.kind != nmm_pkg::MK_SH;
	endsequence

	AST_WORD_LAT: assert property (s_word_go |=> !m.fin [*3] ##1 m.fin)
		else $error("word multiply did not finish on its fifth cycle");
	AST_HALF_LAT: assert property (m.start && m.kind == nmm_pkg::MK_SH |-> ##2 m.fin)
		else $error("half multiply did not finish on its third cycle");
	AST_SW_PROD: assert property (m.start && m.kind == nmm_pkg::MK_SW |-> ##5
		$signed({m.prod_hi, m.prod_lo}) == $signed($past(m.a, 5)) * $signed($past(m.b, 5)))
		else $error("signed word product wrong");
	AST_UW_PROD: assert property (m.start && m.kind == nmm_pkg::MK_UW |-> ##5
		{m.prod_hi, m.prod_lo} == 64'($past(m.a, 5)) * 64'($past(m.b, 5)))
		else $error("unsigned word product wrong");
	AST_SH_PROD: assert property (m.start && m.kind == nmm_pkg::MK_SH |-> ##3
		$signed(m.prod_lo) == $signed($past(m.a[15:0], 3)) * $signed($past(m.b[15:0], 3)))
		else $error("signed half product wrong");
endmodule : nmm_mul
`default_nettype wire

// *** core/nmm_top.sv ***
// byte memory read-modify-write, nibble test and multiply datapath with AHB-Lite registers
//
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - byte xor reads, xors source byte, writes back
// - byte xor sets N,Z; one cycle plus two accesses
// - low and: mask upper ones plus immediate
// - high and: immediate into upper nibble only
// - low or: immediate into lower nibble
// - high or: shifted immediate or into byte
// - low xor: immediate into lower nibble
// - high xor: shifted immediate into byte
// - no hold grant between read and write
// - low test: N cleared, Z, no write
// - high test: N bit 7, Z, no write
// - signed word multiply, 64-bit product, five cycles
// - signed word flags: N, Z, V range
// - unsigned word multiply, 64-bit product, five cycles
// - unsigned flags: N, Z low word, V
// - signed half multiply into product low
// - product high undefined after half multiply
// - half multiply three cycles, N and Z
module nmm_top #(
	parameter int WORD_CYC = nmm_pkg::WORD_MUL_CYC,
	parameter int HALF_CYC = nmm_pkg::HALF_MUL_CYC
) (
	input  wire logic        CLK_SYS_I,
	input  wire logic        RST_I,
	input  wire logic        HSEL_I,
	input  wire logic [31:0] HADDR_I,
	input  wire logic [1:0]  HTRANS_I,
	input  wire logic        HWRITE_I,
	input  wire logic [2:0]  HSIZE_I,
	input  wire logic [31:0] HWDATA_I,
	input  wire logic        HREADY_I,
	output logic      [31:0] HRDATA_O,
	output logic             HREADYOUT_O,
	output logic             HRESP_O,
	output logic             DMEM_REQ_O,
	output logic             DMEM_WE_O,
	output logic      [31:0] DMEM_ADDR_O,
	output logic      [7:0]  DMEM_WDATA_O,
	input  wire logic [7:0]  DMEM_RDATA_I,
	input  wire logic        DMEM_ACK_I,
	input  wire logic        HOLD_REQ_I,
	output logic             HOLD_ACK_O
);
	typedef enum logic [2:0] {S_IDLE, S_RD, S_CALC, S_TEST, S_WR, S_MUL} nmm_st_t;

	typedef struct packed {
		nmm_st_t     st;
		logic [15:0] instr;
		logic [31:0] src;
		logic [31:0] dst;
		logic [3:0]  flags;
		logic [7:0]  byte_v;
		logic        go;
		logic        illegal;
		logic        hold_ack;
		logic [2:0]  hsync;
		logic        hold_f;
		logic        aw;
		logic [7:0]  aoff;
		logic [31:0] rdata;
	} nmm_top_st_t;

	nmm_top_st_t q;
	nmm_top_st_t n;
	nmm_mul_if   mi ();
	logic [7:0]  op;
	logic [3:0]  imm;
	logic [7:0]  res;
	logic        busy;
	logic        is_tst;
	logic        is_rmw;
	logic        is_mul;
	logic        addr_ph;

	// instruction fields: opcode, source index or immediate, destination index
	assign op  = q.instr[15:8];
	assign imm = q.instr[7:4];
	assign busy    = (q.st != S_IDLE) || q.go;
	assign addr_ph = HSEL_I && HTRANS_I[1] && HREADY_I;

	// opcode classes
	always_comb begin
		is_tst = (op == nmm_pkg::OP_TST_LO) || (op == nmm_pkg::OP_TST_HI);
		is_rmw = (op == nmm_pkg::OP_XOR_BYTE) || (op == nmm_pkg::OP_AND_LO)
			|| (op == nmm_pkg::OP_AND_HI) || (op == nmm_pkg::OP_OR_LO)
			|| (op == nmm_pkg::OP_OR_HI) || (op == nmm_pkg::OP_XOR_LO)
			|| (op == nmm_pkg::OP_XOR_HI);
		is_mul = (op == nmm_pkg::OP_MUL_SW) || (op == nmm_pkg::OP_MUL_UW)
			|| (op == nmm_pkg::OP_MUL_SH);
	end

	// byte result of the memory operation; tests keep only the tested nibble
	always_comb begin
		unique case (op)
			nmm_pkg::OP_XOR_BYTE: res = q.byte_v ^ q.src[7:0];
			nmm_pkg::OP_AND_LO:   res = q.byte_v & {nmm_pkg::NIB_ONES, imm};
			nmm_pkg::OP_AND_HI:   res = q.byte_v & {imm, nmm_pkg::NIB_ONES};
			nmm_pkg::OP_OR_LO:    res = q.byte_v | {nmm_pkg::NIB_ZERO, imm};
			nmm_pkg::OP_OR_HI:    res = q.byte_v | {imm, nmm_pkg::NIB_ZERO};
			nmm_pkg::OP_XOR_LO:   res = q.byte_v ^ {nmm_pkg::NIB_ZERO, imm};
			nmm_pkg::OP_XOR_HI:   res = q.byte_v ^ {imm, nmm_pkg::NIB_ZERO};
			nmm_pkg::OP_TST_LO:   res = {nmm_pkg::NIB_ZERO, q.byte_v[3:0] & imm};
			nmm_pkg::OP_TST_HI:   res = {q.byte_v[7:4] & imm, nmm_pkg::NIB_ZERO};
			default:              res = q.byte_v;
		endcase
	end

	// multiplier operands: source times destination register value
	assign mi.a = q.src;
	assign mi.b = q.dst;
	always_comb begin
		unique case (op)
			nmm_pkg::OP_MUL_UW: mi.kind = nmm_pkg::MK_UW;
			nmm_pkg::OP_MUL_SH: mi.kind = nmm_pkg::MK_SH;
			default:            mi.kind = nmm_pkg::MK_SW;
		endcase
	end

	nmm_mul #(
		.WORD_CYC (WORD_CYC),
		.HALF_CYC (HALF_CYC)
	) u_mul (
		.clk_i (CLK_SYS_I),
		.rst_i (RST_I),
		.m     (mi.mul)
	);

	// next-state logic for sequencer, hold arbitration and register file
	always_comb begin
		n = q;
		mi.start = 1'b0;
		// hold request synchroniser; a level counts once stages two and three agree
		n.hsync = {q.hsync[1:0], HOLD_REQ_I};
		if (q.hsync[1] == q.hsync[2]) begin
			n.hold_f = q.hsync[2];
		end
		// grant only while idle so a read and its write are never split
		n.hold_ack = q.hold_f && (q.st == S_IDLE) && (q.hold_ack || !q.go);
		unique case (q.st)
			S_IDLE: begin
				if (q.go && !q.hold_ack) begin
					n.go = 1'b0;
					if (is_rmw || is_tst) begin
						n.st = S_RD;
					end else if (is_mul) begin
						mi.start = 1'b1;
						n.st = S_MUL;
					end else begin
						n.illegal = 1'b1;
					end
				end
			end
			S_RD: begin
				// stay as long as the memory inserts wait states
				if (DMEM_ACK_I) begin
					n.byte_v = DMEM_RDATA_I;
					n.st = S_CALC;
				end
			end
			S_CALC: begin
				if (is_tst) begin
					n.flags[nmm_pkg::FLAG_N] = res[7];
					n.flags[nmm_pkg::FLAG_Z] = (res == 8'h00);
					n.st = S_TEST;
				end else begin
					n.byte_v = res;
					if (op == nmm_pkg::OP_XOR_BYTE) begin
						n.flags[nmm_pkg::FLAG_N] = res[7];
						n.flags[nmm_pkg::FLAG_Z] = (res == 8'h00);
					end
					n.st = S_WR;
				end
			end
			S_TEST: begin
				n.st = S_IDLE;
			end
			S_WR: begin
				if (DMEM_ACK_I) begin
					n.st = S_IDLE;
				end
			end
			S_MUL: begin
				if (mi.fin) begin
					n.flags[nmm_pkg::FLAG_N] = mi.flag_n;
					n.flags[nmm_pkg::FLAG_Z] = mi.flag_z;
					if (mi.v_upd) begin
						n.flags[nmm_pkg::FLAG_V] = mi.flag_v;
					end
					n.st = S_IDLE;
				end
			end
		endcase
		// bus data phase; software writes are dropped while an operation runs
		if (q.aw && !busy) begin
			unique case (q.aoff)
				nmm_pkg::OFF_INSTR: begin
					n.instr   = HWDATA_I[15:0];
					n.go      = 1'b1;
					n.illegal = 1'b0;
				end
				nmm_pkg::OFF_SRC:   n.src = HWDATA_I;
				nmm_pkg::OFF_DST:   n.dst = HWDATA_I;
				nmm_pkg::OFF_FLAGS: n.flags = HWDATA_I[3:0];
				default: begin
				end
			endcase
		end
		// bus address phase; read data is captured here for the data phase
		n.aw   = addr_ph && HWRITE_I;
		n.aoff = HADDR_I[7:0];
		if (addr_ph && !HWRITE_I) begin
			unique case (HADDR_I[7:0])
				nmm_pkg::OFF_INSTR:  n.rdata = {16'h0000, q.instr};
				nmm_pkg::OFF_SRC:    n.rdata = q.src;
				nmm_pkg::OFF_DST:    n.rdata = q.dst;
				nmm_pkg::OFF_FLAGS:  n.rdata = {28'h0000000, q.flags};
				nmm_pkg::OFF_PROD_H: n.rdata = mi.prod_hi;
				nmm_pkg::OFF_PROD_L: n.rdata = mi.prod_lo;
				nmm_pkg::OFF_STATUS: n.rdata = {8'h00, q.byte_v, q.instr[3:0], imm,
					5'h00, q.hold_ack, q.illegal, busy};
				default:             n.rdata = nmm_pkg::WORD_RST;
			endcase
		end
	end

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	// outputs; address and data are held registers, strobes follow the state
	assign HRDATA_O     = q.rdata;
	assign HREADYOUT_O  = 1'b1;
	assign HRESP_O      = 1'b0;
	assign DMEM_REQ_O   = (q.st == S_RD) || (q.st == S_WR);
	assign DMEM_WE_O    = (q.st == S_WR);
	assign DMEM_ADDR_O  = q.dst;
	assign DMEM_WDATA_O = q.byte_v;
	assign HOLD_ACK_O   = q.hold_ack;

	// checks run on the system clock and sleep through reset
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);

	// steps of a read-modify-write as the checks below see them
	sequence s_read_done;
		q.st == S_RD && DMEM_ACK_I;
	endsequence
	sequence s_modify;
		q.st == S_CALC && !is_tst;
	endsequence

	AST_NO_HOLD_RMW: assert property (DMEM_REQ_O || q.st == S_CALC |-> !HOLD_ACK_O)
		else $error("hold granted inside a memory operation");
	AST_RMW_ORDER: assert property (s_read_done ##1 s_modify |=>
		DMEM_REQ_O && DMEM_WE_O && DMEM_ADDR_O == $past(DMEM_ADDR_O, 2))
		else $error("write back did not follow the read");
	AST_XOR_DATA: assert property (q.st == S_CALC && op == nmm_pkg::OP_XOR_BYTE |=>
		DMEM_WDATA_O == ($past(q.byte_v) ^ q.src[7:0]) && q.flags[2] == (DMEM_WDATA_O == 8'h00))
		else $error("byte xor result or zero flag wrong");
	AST_NIB_FLAGS: assert property (q.st == S_CALC && is_rmw
		&& op != nmm_pkg::OP_XOR_BYTE |=> $stable(q.flags))
		else $error("nibble operation changed flags");
	AST_HI_AND_KEEP: assert property (q.st == S_CALC && op == nmm_pkg::OP_AND_HI |=>
		DMEM_WDATA_O[3:0] == $past(q.byte_v[3:0]))
		else $error("high and disturbed the lower nibble");
	AST_TEST_NO_WRITE: assert property (q.st == S_CALC && is_tst |=>
		!DMEM_REQ_O ##1 q.st == S_IDLE && !DMEM_REQ_O)
		else $error("test wrote memory or overran two cycles");
	AST_TSTL_N: assert property (q.st == S_CALC && op == nmm_pkg::OP_TST_LO |=>
		!q.flags[3] && $stable(q.flags[1:0]))
		else $error("low test left N set or touched V or C");
	AST_MUL_C_KEEP: assert property (mi.fin |=> $stable(q.flags[0]))
		else $error("multiply changed C");

	// byte xor takes N from bit 7 of the byte it writes; V and C must survive
	AST_XOR_N: assert property (q.st == S_CALC && op == nmm_pkg::OP_XOR_BYTE |=>
		q.flags[nmm_pkg::FLAG_N] == DMEM_WDATA_O[7] && $stable(q.flags[1:0]))
		else $error("byte xor N flag wrong or V and C touched");

	// the high test masks bit 7 with the top immediate bit, leaving V and C alone
	AST_TSTH_N: assert property (q.st == S_CALC && op == nmm_pkg::OP_TST_HI |=>
		q.flags[nmm_pkg::FLAG_N] == (q.byte_v[7] & imm[3]) && $stable(q.flags[1:0]))
		else $error("high test N flag wrong or V and C touched");

	// a pending operation must sit out a granted hold rather than split it later
	AST_HOLD_DEFER: assert property (q.go && HOLD_ACK_O |=> q.st == S_IDLE)
		else $error("operation started under a granted hold");

	// wait states: the request and all that qualifies it stand until acknowledged
	AST_REQ_STANDS: assert property (DMEM_REQ_O && !DMEM_ACK_I |=> DMEM_REQ_O
		&& $stable(DMEM_WE_O) && $stable(DMEM_ADDR_O) && $stable(DMEM_WDATA_O))
		else $error("memory request changed before its acknowledge");
endmodule : nmm_top
`default_nettype wire

// *** bench/nmm_mem_model.sv ***
// behavioural byte memory on the data side, with programmable wait states
`timescale 1ns/1ps
`default_nettype none
module nmm_mem_model (
	input  wire logic        clk_i,
	input  wire logic        req_i,
	input  wire logic        we_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic [1:0]  wait_i,
	output logic      [7:0]  rdata_o,
	output logic             ack_o
);
	logic [7:0] mem [256];
	logic [1:0] cnt_q  = 2'h0;
	logic [7:0] last_q = 8'h00;
	// ack after the programmed wait states, one cycle per access
	assign ack_o = req_i & (cnt_q == wait_i);
	// idle data is the inverse of the last byte so a stale sample never matches
	assign rdata_o = (ack_o & ~we_i) ? mem[addr_i[7:0]] : ~last_q;
	// wait counter, last byte seen and the write port
	always @(posedge clk_i) begin
		cnt_q <= (req_i & ~ack_o) ? cnt_q + 2'h1 : 2'h0;
		if (ack_o)
			last_q <= we_i ? wdata_i : rdata_o;
		if (ack_o & we_i)
			mem[addr_i[7:0]] <= wdata_i;
	end
endmodule : nmm_mem_model
`default_nettype wire

// *** bench/nmm_top_tb_top.sv ***
// self-checking bench for the nibble memory-op and multiplier block
`timescale 1ns/1ps
`default_nettype none
module nmm_top_tb_top;
	logic        clk      = 1'b0;
	logic        rst      = 1'b1;
	logic        hsel     = 1'b0;
	logic [31:0] haddr    = 32'h0;
	logic [1:0]  htrans   = 2'h0;
	logic        hwrite   = 1'b0;
	logic [31:0] hwdata   = 32'h0;
	logic        hold_req = 1'b0;
	logic [1:0]  mem_wait = 2'h0;
	logic        rmw_exp  = 1'b0;
	logic        in_rmw   = 1'b0;
	int          wcount   = 0;
	int          miscompares  = 0;
	int          total_checks = 0;
	wire logic        hready, hresp, dreq, dwe, dack, hold_ack;
	wire logic [31:0] hrdata, daddr;
	wire logic [7:0]  dwdata, drdata;

	nmm_top u_nmm_top (
		.CLK_SYS_I   (clk),
		.RST_I       (rst),
		.HSEL_I      (hsel),
		.HADDR_I     (haddr),
		.HTRANS_I    (htrans),
		.HWRITE_I    (hwrite),
		.HSIZE_I     (3'h2),
		.HWDATA_I    (hwdata),
		.HREADY_I    (hready),
		.HRDATA_O    (hrdata),
		.HREADYOUT_O (hready),
		.HRESP_O     (hresp),
		.DMEM_REQ_O  (dreq),
		.DMEM_WE_O   (dwe),
		.DMEM_ADDR_O (daddr),
		.DMEM_WDATA_O(dwdata),
		.DMEM_RDATA_I(drdata),
		.DMEM_ACK_I  (dack),
		.HOLD_REQ_I  (hold_req),
		.HOLD_ACK_O  (hold_ack)
	);
	nmm_mem_model u_nmm_mem_model (
		.clk_i  (clk),
		.req_i  (dreq),
		.we_i   (dwe),
		.addr_i (daddr),
		.wdata_i(dwdata),
		.wait_i (mem_wait),
		.rdata_o(drdata),
		.ack_o  (dack)
	);

	// 20 mhz system clock
	always #25 clk = ~clk;

	// a hold grant between the read and the write would break atomicity
	always @(posedge clk) begin
		if (dreq && dack) begin
			in_rmw <= ~dwe & rmw_exp;
			if (dwe)
				wcount <= wcount + 1;
		end
		if (in_rmw && hold_ack === 1'b1) begin
			miscompares++;
			$display("unexpected at %0t: hold granted inside read-modify-write", $time);
		end
	end

	task automatic summarize;
		if (miscompares == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// waits for hready at a bounded count; data taken at the rising edge that samples it
	task automatic rdy(output logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		while (hready !== 1'b1) begin
			n++;
			if (n > 50) begin
				miscompares++;
				summarize();
			end
			@(posedge clk);
		end
		d = hrdata;
	endtask : rdy

	// one single ahb-lite transfer: address phase, then data phase
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rdat);
		logic [31:0] x;
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		rdy(x);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		rdy(rdat);
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask : wr

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		ahb(1'b0, a, 32'h0, d);
		chk(d, e);
	endtask : rdc

	// start an operation and poll busy under a bounded count
	task automatic run(input logic [15:0] ins);
		logic [31:0] s;
		int n;
		wr(nmm_pkg::OFF_INSTR, {16'h0, ins});
		n = 0;
		do begin
			ahb(1'b0, nmm_pkg::OFF_STATUS, 32'h0, s);
			n++;
		end while (s[0] !== 1'b0 && n < 100);
		if (s[0] !== 1'b0) begin
			miscompares++;
			summarize();
		end
	endtask : run

	task automatic sc_regs;
		logic [31:0] s;
		chk(hresp, 1'b0);
		rdc(nmm_pkg::OFF_FLAGS, 32'h0);
		rdc(nmm_pkg::OFF_PROD_H, 32'h0);
		rdc(nmm_pkg::OFF_STATUS, 32'h0);
		wr(8'h1c, 32'hffff_ffff);
		rdc(8'h1c, 32'h0);
		wr(nmm_pkg::OFF_PROD_L, 32'hffff_ffff);
		rdc(nmm_pkg::OFF_PROD_L, 32'h0);
		run(16'h0012);
		ahb(1'b0, nmm_pkg::OFF_STATUS, 32'h0, s);
		chk(s[1:0], 2'h2);
	endtask : sc_regs

	// byte xor with a hold request arriving mid-operation
	task automatic sc_xor;
		logic [31:0] src [2];
		logic [3:0]  fl [2];
		src = '{32'hffff_ff8f, 32'h0000_000f};
		fl = '{4'hb, 4'h7};
		mem_wait <= 2'h2;
		rmw_exp <= 1'b1;
		for (int i = 0; i < 2; i++) begin
			u_nmm_mem_model.mem[8'h20] = 8'h0f;
			wr(nmm_pkg::OFF_FLAGS, 32'h3);
			wr(nmm_pkg::OFF_SRC, src[i]);
			wr(nmm_pkg::OFF_DST, 32'h0000_0120);
			fork
				run({nmm_pkg::OP_XOR_BYTE, 8'h12});
				begin
					repeat (4) @(posedge clk);
					hold_req <= (i == 0);
				end
			join
			chk(u_nmm_mem_model.mem[8'h20], {24'h0, src[i][7:0] ^ 8'h0f});
			rdc(nmm_pkg::OFF_FLAGS, {28'h0, fl[i]});
			if (i == 0) begin
				repeat (8) @(posedge clk);
				chk(hold_ack, 1'b1);
			end
		end
		repeat (8) @(posedge clk);
		chk(hold_ack, 1'b0);
	endtask : sc_xor

	// all six nibble read-modify-write ops, varying wait states
	task automatic sc_nib;
		logic [7:0] ops [6];
		logic [7:0] b, m, e;
		logic [3:0] imm;
		ops = '{nmm_pkg::OP_AND_LO, nmm_pkg::OP_AND_HI, nmm_pkg::OP_OR_LO,
			nmm_pkg::OP_OR_HI, nmm_pkg::OP_XOR_LO, nmm_pkg::OP_XOR_HI};
		rmw_exp <= 1'b1;
		wr(nmm_pkg::OFF_FLAGS, 32'ha);
		for (int i = 0; i < 6; i++) begin
			b = 8'h5a + 8'(i * 37);
			imm = 4'h9 ^ 4'(i);
			m = i[0] ? {imm, 4'h0} : {4'h0, imm};
			case (i / 2)
				0: e = b & (i[0] ? {imm, 4'hf} : {4'hf, imm});
				1: e = b | m;
				default: e = b ^ m;
			endcase
			mem_wait <= 2'(i % 3);
			u_nmm_mem_model.mem[8'h40 + 8'(i)] = b;
			wr(nmm_pkg::OFF_DST, 32'h40 + 32'(i));
			run({ops[i], imm, 4'h5});
			chk(u_nmm_mem_model.mem[8'h40 + 8'(i)], e);
			rdc(nmm_pkg::OFF_FLAGS, 32'ha);
		end
	endtask : sc_nib

	task automatic sc_tst;
		int w0;
		rmw_exp <= 1'b0;
		mem_wait <= 2'h1;
		u_nmm_mem_model.mem[8'h60] = 8'hfa;
		wr(nmm_pkg::OFF_DST, 32'h60);
		wr(nmm_pkg::OFF_FLAGS, 32'h9);
		w0 = wcount;
		run({nmm_pkg::OP_TST_LO, 8'h53});
		rdc(nmm_pkg::OFF_FLAGS, 32'h5);
		u_nmm_mem_model.mem[8'h60] = 8'h80;
		wr(nmm_pkg::OFF_FLAGS, 32'h6);
		run({nmm_pkg::OP_TST_HI, 8'h83});
		rdc(nmm_pkg::OFF_FLAGS, 32'ha);
		chk(wcount - w0, 32'h0);
	endtask : sc_tst

	// product high is not checked after half multiplies, it is undefined there
	task automatic sc_mul;
		logic [7:0]  op [6];
		logic [31:0] a [6], b [6], h [6], l [6];
		logic [3:0]  f [6];
		op = '{nmm_pkg::OP_MUL_SW, nmm_pkg::OP_MUL_SW, nmm_pkg::OP_MUL_UW,
			nmm_pkg::OP_MUL_UW, nmm_pkg::OP_MUL_SH, nmm_pkg::OP_MUL_SH};
		a = '{32'hffff_fffe, 32'h1_0000, 32'h1_0000, 32'hffff_ffff, 32'h1234_fff0, 32'h1_0000};
		b = '{32'h3, 32'h1_0000, 32'h1_0000, 32'h1, 32'h10, 32'h5};
		h = '{32'hffff_ffff, 32'h1, 32'h1, 32'h0, 32'h0, 32'h0};
		l = '{32'hffff_fffa, 32'h0, 32'h0, 32'hffff_ffff, 32'hffff_ff00, 32'h0};
		f = '{4'h9, 4'h3, 4'h7, 4'h9, 4'hb, 4'h7};
		for (int i = 0; i < 6; i++) begin
			wr(nmm_pkg::OFF_FLAGS, 32'h3);
			wr(nmm_pkg::OFF_SRC, a[i]);
			wr(nmm_pkg::OFF_DST, b[i]);
			run({op[i], 8'h21});
			if (i < 4)
				rdc(nmm_pkg::OFF_PROD_H, h[i]);
			rdc(nmm_pkg::OFF_PROD_L, l[i]);
			rdc(nmm_pkg::OFF_FLAGS, {28'h0, f[i]});
		end
	endtask : sc_mul

	// reset for ten cycles, then the scenarios in turn
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		sc_regs();
		sc_xor();
		sc_nib();
		sc_tst();
		sc_mul();
		summarize();
	end
endmodule : nmm_top_tb_top
`default_nettype wire
